/* rtl/ocr_delay_timer.sv */
`include "ocr_cfg.svh"

// counts time-unit ticks up to 2^units_log2 and then pulses done
module ocr_delay_timer
    import ocr_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic             start,
    input  wire logic             unit_tick,
    input  wire logic [2:0]       units_log2,
    output logic                  done
);

    ocr_timer_s r_reg;   // registered state
    ocr_timer_s r_next;  // next state
    logic [CNT_W-1:0] target;  // number of units to wait

    // delay code n stands for 2^n units, 1 up to 128
    assign target = CNT_W'(1) << units_log2;

    // next state
    always_comb begin
        r_next      = r_reg;
        r_next.done = 1'b0;
        if (start) begin
            // a new start restarts the count from zero
            r_next.busy = 1'b1;
            r_next.cnt  = '0;
        end else if (r_reg.busy && unit_tick) begin
            // unit length is set elsewhere, we only count its ticks
            r_next.cnt = r_reg.cnt + CNT_W'(1);
            if (r_next.cnt == target) begin
                r_next.busy = 1'b0;
                r_next.done = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign done = r_reg.done;

endmodule : ocr_delay_timer

/* rtl/ocr_fault_ctrl.sv */
`include "ocr_cfg.svh"

// over-current fault response controller
module ocr_fault_ctrl
    import ocr_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic [7:0] cmd_code,          // command code of current transaction
    input  wire logic       cmd_wr,            // one-cycle write strobe
    input  wire logic [7:0] cmd_wdata,         // written byte
    input  wire logic       oc_detect,         // current above overcurrent_limit_level
    input  wire logic       vout_below_floor,  // vout under overcurrent_low_voltage_floor
    input  wire logic       unit_tick,         // one pulse per delay time unit
    input  wire logic       output_on_cmd,     // output commanded on
    input  wire logic       other_fault_off,   // another fault shuts the unit down
    input  wire logic       fault_clear,       // one-cycle fault clear
    output logic [7:0]      cfg_rdata,         // overcurrent_fault_response_cfg readback
    output logic            output_enable,     // power stage enable
    output logic            current_limit,     // clamp current at the limit
    output logic            oc_fault_status,   // sticky over-current fault bit
    output logic            host_notify        // one-cycle host notification
);

    ocr_ctrl_s  r_reg;       // registered state
    ocr_ctrl_s  r_next;      // next state
    logic       tmr_start;   // launch delay timer
    logic       tmr_done;    // delay expired
    ocr_resp_e  resp;        // decoded response field
    logic [2:0] retry;       // retry field
    logic       enable_rise; // output newly commanded on

    assign resp        = ocr_resp_e'(r_reg.cfg[`OCR_RESP_MSB:`OCR_RESP_LSB]);
    assign retry       = r_reg.cfg[`OCR_RETRY_MSB:`OCR_RETRY_LSB];
    assign enable_rise = output_on_cmd & ~r_reg.en_q;

    // one timer serves both the limit delay and the retry spacing
    ocr_delay_timer #(
        .CNT_W      (8)
    ) u_timer (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .start      (tmr_start),
        .unit_tick  (unit_tick),
        .units_log2 (r_reg.cfg[`OCR_DELAY_MSB:`OCR_DELAY_LSB]),
        .done       (tmr_done)
    );

    // next state
    always_comb begin
        logic shut;  // a fault shutdown happens this cycle
        shut         = 1'b0;
        r_next       = r_reg;
        tmr_start    = 1'b0;
        r_next.en_q  = output_on_cmd;
        r_next.notify = 1'b0;

        // configuration write
        if (cmd_wr && cmd_code == `OCR_CMD_CFG) begin
            r_next.cfg = cmd_wdata;
        end
        // readback only answers for our own command code
        r_next.rdata = (cmd_code == `OCR_CMD_CFG) ? r_reg.cfg : `OCR_RDATA_NONE;

        // sticky status, a new fault beats a clear in the same cycle
        r_next.status = r_reg.status & ~fault_clear;
        if (oc_detect && r_reg.out_en) begin
            r_next.status = 1'b1;
            r_next.notify = ~r_reg.status;
        end

        unique case (r_reg.state)
            OCR_ST_OFF: begin
                r_next.out_en = 1'b0;
                r_next.limit  = 1'b0;
                if (enable_rise && !other_fault_off) begin
                    r_next.left   = retry;
                    r_next.state  = OCR_ST_RUN;
                    r_next.out_en = 1'b1;
                end
            end
            OCR_ST_RUN: begin
                r_next.out_en = 1'b1;
                r_next.limit  = 1'b0;
                if (oc_detect) begin
                    unique case (resp)
                        OCR_RESP_IGNORE: begin
                            r_next.limit = 1'b1;
                        end
                        OCR_RESP_COND: begin
                            if (vout_below_floor) begin
                                shut = 1'b1;
                            end else begin
                                r_next.limit = 1'b1;
                            end
                        end
                        OCR_RESP_DELAY: begin
                            r_next.limit = 1'b1;
                            r_next.state = OCR_ST_LIMIT;
                            tmr_start    = 1'b1;
                        end
                        OCR_RESP_DISABLE: begin
                            shut = 1'b1;
                        end
                    endcase
                end
            end
            OCR_ST_LIMIT: begin
                // keep limiting whatever the output voltage does
                r_next.out_en = 1'b1;
                r_next.limit  = 1'b1;
                if (tmr_done) begin
                    if (oc_detect) begin
                        shut = 1'b1;
                    end else begin
                        r_next.state = OCR_ST_RUN;
                        r_next.limit = 1'b0;
                    end
                end
            end
            OCR_ST_WAIT: begin
                // output off while the spacing between attempts runs
                r_next.out_en = 1'b0;
                r_next.limit  = 1'b0;
                if (tmr_done) begin
                    r_next.state  = OCR_ST_RUN;
                    r_next.out_en = 1'b1;
                end
            end
            OCR_ST_LATCH: begin
                // off until the fault is cleared
                r_next.out_en = 1'b0;
                r_next.limit  = 1'b0;
                if (fault_clear) begin
                    r_next.left   = retry;
                    r_next.state  = output_on_cmd ? OCR_ST_RUN : OCR_ST_OFF;
                    r_next.out_en = output_on_cmd;
                end
            end
            default: begin
                // illegal code, recover safely with the output off
                r_next.state  = OCR_ST_OFF;
                r_next.out_en = 1'b0;
                r_next.limit  = 1'b0;
            end
        endcase

        // shutdown, then the retry field decides what follows
        if (shut) begin
            r_next.out_en = 1'b0;
            r_next.limit  = 1'b0;
            if (retry == `OCR_RETRY_NONE) begin
                r_next.state = OCR_ST_LATCH;
            end else if (retry == `OCR_RETRY_CONT) begin
                r_next.state = OCR_ST_WAIT;
                tmr_start    = 1'b1;
            end else if (r_reg.left == 3'h0) begin
                // attempts used up: 1..6 attempts end here
                r_next.state = OCR_ST_LATCH;
            end else begin
                r_next.left  = r_reg.left - 3'h1;
                r_next.state = OCR_ST_WAIT;
                tmr_start    = 1'b1;
            end
        end

        // commanded off or another fault ends everything, retries too
        if (!output_on_cmd || other_fault_off) begin
            r_next.state  = OCR_ST_OFF;
            r_next.out_en = 1'b0;
            r_next.limit  = 1'b0;
            tmr_start     = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            r_reg       <= '0;
            r_reg.state <= OCR_ST_OFF;
            r_reg.cfg   <= `OCR_CFG_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // outputs straight from the register
    assign cfg_rdata       = r_reg.rdata;
    assign output_enable   = r_reg.out_en;
    assign current_limit   = r_reg.limit;
    assign oc_fault_status = r_reg.status;
    assign host_notify     = r_reg.notify;

    // checks
    logic stay_on;  // nothing external forces the output off
    assign stay_on = output_on_cmd & ~other_fault_off;

    logic shut_seen;  // helper: a shutdown left a running state
    assign shut_seen = (r_reg.state == OCR_ST_RUN || r_reg.state == OCR_ST_LIMIT)
                       && r_reg.out_en && !r_next.out_en;

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    chk_status_set: assert property (
        oc_detect && output_enable |=> oc_fault_status)
        else $error("fault status not set on over-current");

    chk_ignore_runs: assert property (
        r_reg.state == OCR_ST_RUN && resp == OCR_RESP_IGNORE && oc_detect && stay_on
        |=> output_enable && current_limit)
        else $error("ignore mode did not keep running clamped");

    chk_cond_clamp: assert property (
        r_reg.state == OCR_ST_RUN && resp == OCR_RESP_COND && oc_detect
        && !vout_below_floor && stay_on |=> output_enable && current_limit)
        else $error("conditioned mode did not clamp");

    chk_cond_trip: assert property (
        r_reg.state == OCR_ST_RUN && resp == OCR_RESP_COND && oc_detect
        && vout_below_floor |=> !output_enable)
        else $error("low voltage did not shut output down");

    chk_delay_hold: assert property (
        r_reg.state == OCR_ST_LIMIT && !tmr_done && stay_on
        |=> output_enable && current_limit)
        else $error("output dropped during limit delay");

    chk_delay_trip: assert property (
        r_reg.state == OCR_ST_LIMIT && tmr_done && oc_detect |=> !output_enable)
        else $error("still limiting at expiry but output kept on");

    chk_disable_now: assert property (
        r_reg.state == OCR_ST_RUN && resp == OCR_RESP_DISABLE && oc_detect
        |=> !output_enable)
        else $error("disable mode did not shut output at once");

    // only the next cycle is known: a clear one cycle later may legally restart
    chk_no_retry: assert property (
        r_reg.state == OCR_ST_LATCH && !fault_clear
        |=> !output_enable && r_reg.state != OCR_ST_RUN)
        else $error("latched output came back without clear");

    chk_cont_retry: assert property (
        shut_seen && retry == `OCR_RETRY_CONT && stay_on |=> r_reg.state == OCR_ST_WAIT)
        else $error("continuous retry stopped");

endmodule : ocr_fault_ctrl

/* shared/ocr_cfg.svh */
`ifndef OCR_CFG_SVH
`define OCR_CFG_SVH
// Summary of operation
// - over-current while output enabled sets status, notifies host when status first sets
// - code 00: run on, brickwall current clamp
// - code 01: clamp while voltage above floor
// - code 01: below floor, shut down, retry
// - code 10: limit for delay regardless voltage
// - code 10: still limiting at expiry, retry
// - code 11: disable at once, then retry
// - retry field counts restart attempts
// - retry 000: never restart, stay off
// - retry 1..5: that many attempts, then latch
// - retry 111: retry without limit
// - attempts spaced by delay times unit
// - delay field n means 2^n units
// - unit length comes from separate config
// - retry 110: six attempts, then latch
// - continuous retry ends on off or fault

// command code of the response configuration byte
`define OCR_CMD_CFG      8'h47
// configuration value after reset: disable and latch off
`define OCR_CFG_RST      8'hC0
// field positions inside the configuration byte
`define OCR_RESP_MSB     7
`define OCR_RESP_LSB     6
`define OCR_RETRY_MSB    5
`define OCR_RETRY_LSB    3
`define OCR_DELAY_MSB    2
`define OCR_DELAY_LSB    0
// retry field codes with special meaning
`define OCR_RETRY_NONE   3'h0
`define OCR_RETRY_CONT   3'h7
// read data for a command code this block does not own
`define OCR_RDATA_NONE   8'h00
`endif

/* shared/ocr_pkg.sv */
package ocr_pkg;

    // response selected by the top two configuration bits
    typedef enum logic [1:0] {
        OCR_RESP_IGNORE  = 2'b00,
        OCR_RESP_COND    = 2'b01,
        OCR_RESP_DELAY   = 2'b10,
        OCR_RESP_DISABLE = 2'b11
    } ocr_resp_e;

    // fault handling sequence
    typedef enum logic [2:0] {
        OCR_ST_OFF   = 3'b000,
        OCR_ST_RUN   = 3'b001,
        OCR_ST_LIMIT = 3'b010,
        OCR_ST_WAIT  = 3'b011,
        OCR_ST_LATCH = 3'b100
    } ocr_state_e;

    // delay timer state
    typedef struct packed {
        logic       busy;
        logic [7:0] cnt;
        logic       done;
    } ocr_timer_s;

    // controller state
    typedef struct packed {
        ocr_state_e state;
        logic [7:0] cfg;
        logic [2:0] left;
        logic       en_q;
        logic       out_en;
        logic       limit;
        logic       status;
        logic       notify;
        logic [7:0] rdata;
    } ocr_ctrl_s;

endpackage : ocr_pkg

/* tb/ocr_host_model.sv */
`include "ocr_cfg.svh"

// host side of the command link: byte writes, byte reads, alert count
module ocr_host_model
    import ocr_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic [7:0] cfg_rdata,
    input  wire logic       host_notify,
    output logic [7:0]      cmd_code,
    output logic            cmd_wr,
    output logic [7:0]      cmd_wdata
);
    timeunit 1ns;
    timeprecision 100ps;

    int n_notify = 0; // notifications seen so far

    // idle bus at time zero
    initial begin
        cmd_code = 8'h00;
        cmd_wr = 1'b0;
        cmd_wdata = 8'h00;
    end

    // count one per notify pulse, never during reset
    always @(posedge clock) begin
        if (!sys_rst && host_notify === 1'b1) begin
            n_notify <= n_notify + 1;
        end
    end

    // one write strobe; data inverted afterwards so a stale byte never matches
    task automatic write_cfg(input logic [7:0] code, input logic [7:0] data);
        @(posedge clock);
        cmd_code <= code;
        cmd_wr <= 1'b1;
        cmd_wdata <= data;
        @(posedge clock);
        cmd_wr <= 1'b0;
        cmd_wdata <= ~data;
    endtask : write_cfg

    // readback lags the code by one cycle, so hold it two edges
    task automatic read_cfg(input logic [7:0] code, output logic [7:0] data);
        @(posedge clock);
        cmd_code <= code;
        repeat (2) @(posedge clock);
        data = cfg_rdata;
        cmd_code <= ~code;
    endtask : read_cfg
endmodule : ocr_host_model

/* tb/tb.sv */
`include "ocr_cfg.svh"

module tb
    import ocr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic       clock = 1'b0;     // 100 MHz
    logic       sys_rst = 1'b1;   // sync reset
    logic [7:0] cmd_code;         // from host model
    logic       cmd_wr;
    logic [7:0] cmd_wdata;
    logic       oc_detect = 1'b0;
    logic       vout_below_floor = 1'b0;
    logic       unit_tick = 1'b0;
    logic       output_on_cmd = 1'b0;
    logic       other_fault_off = 1'b0;
    logic       fault_clear = 1'b0;
    logic [7:0] cfg_rdata;
    logic       output_enable;
    logic       current_limit;
    logic       oc_fault_status;
    logic       host_notify;
    int         error_cnt = 0;
    int         n_compared = 0;
    logic [7:0] rd;
    int         n;
    int         n0;
    logic [2:0] retry_set [5] = '{3'h0, 3'h1, 3'h5, 3'h6, 3'h7};  // retry codes exercised

    // free running clock
    always #5 clock = ~clock;

    ocr_fault_ctrl ocr_fault_ctrl_i (
        .clock(clock), .sys_rst(sys_rst), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
        .cmd_wdata(cmd_wdata), .oc_detect(oc_detect), .vout_below_floor(vout_below_floor),
        .unit_tick(unit_tick), .output_on_cmd(output_on_cmd),
        .other_fault_off(other_fault_off), .fault_clear(fault_clear),
        .cfg_rdata(cfg_rdata), .output_enable(output_enable),
        .current_limit(current_limit), .oc_fault_status(oc_fault_status),
        .host_notify(host_notify)
    );

    ocr_host_model host_i (
        .clock(clock), .sys_rst(sys_rst), .cfg_rdata(cfg_rdata),
        .host_notify(host_notify), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
        .cmd_wdata(cmd_wdata)
    );

    task automatic close_out();
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    // drives are placed right after these edges
    task automatic step(input int k);
        repeat (k) @(posedge clock);
    endtask : step

    task automatic chk_bit(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask : chk_bit

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: %s got %0d want %0d", $time, what, got, exp);
        end
    endtask : chk_val

    // bounded wait on the enable; running out ends the run
    task automatic wait_oe(input logic exp);
        for (int k = 0; k < 40 && output_enable !== exp; k++) begin
            @(posedge clock);
            #1;
        end
        chk_bit(output_enable, exp, "enable wait ran out");
        if (output_enable !== exp) close_out();
    endtask : wait_oe

    // time unit pulses come from outside, one cycle each
    task automatic tick(input int k);
        repeat (k) begin
            step(1);
            unit_tick <= 1'b1;
            step(1);
            unit_tick <= 1'b0;
        end
    endtask : tick

    // back to a quiet, cleared, commanded-off state
    task automatic quiet();
        step(1);
        {oc_detect, vout_below_floor, output_on_cmd, other_fault_off} <= 4'h0;
        fault_clear <= 1'b1;
        step(1);
        fault_clear <= 1'b0;
        step(3);
    endtask : quiet

    // disable-and-retry: count restarts over up to seven shutdowns
    task automatic run_retry(input logic [2:0] r);
        n = 0;
        n0 = host_i.n_notify;
        host_i.write_cfg(`OCR_CMD_CFG, {OCR_RESP_DISABLE, r, 3'h1});
        step(1);
        output_on_cmd <= 1'b1;
        wait_oe(1'b1);
        for (int i = 0; i < 7; i++) begin
            step(1);
            oc_detect <= 1'b1;
            step(2);
            #1;
            chk_bit(output_enable, 1'b0, "no immediate shutdown");
            chk_bit(oc_fault_status, 1'b1, "status not set");
            step(1);
            oc_detect <= 1'b0;
            tick(1);
            step(3);
            #1;
            chk_bit(output_enable, 1'b0, "restart before two units");
            tick(1);
            step(3);
            #1;
            if (output_enable !== 1'b1) break;
            n++;
        end
        chk_val(n, (r == `OCR_RETRY_CONT) ? 7 : r, "restart count");
        chk_val(host_i.n_notify - n0, 1, "notify count");
        if (r != `OCR_RETRY_CONT) begin
            tick(3);
            step(3);
            #1;
            chk_bit(output_enable, 1'b0, "latched output came back");
            step(1);
            fault_clear <= 1'b1;
            step(1);
            fault_clear <= 1'b0;
            wait_oe(1'b1);
            step(1);
            oc_detect <= 1'b1;
            step(1);
            oc_detect <= 1'b0;
            tick(2);
            step(3);
            #1;
            chk_bit(output_enable, r != `OCR_RETRY_NONE, "attempts not reloaded");
        end else begin
            step(1);
            other_fault_off <= 1'b1;
            step(2);
            #1;
            chk_bit(output_enable, 1'b0, "other fault did not stop retry");
        end
        quiet();
    endtask : run_retry

    // main sequence
    initial begin
        step(16);
        sys_rst <= 1'b0;
        step(1);
        #1;
        chk_bit(output_enable, 1'b0, "enable after reset");
        chk_bit(oc_fault_status, 1'b0, "status after reset");
        host_i.read_cfg(`OCR_CMD_CFG, rd);
        chk_val(rd, `OCR_CFG_RST, "reset config");
        host_i.write_cfg(8'h46, 8'h00);
        host_i.read_cfg(`OCR_CMD_CFG, rd);
        chk_val(rd, `OCR_CFG_RST, "foreign code wrote config");
        host_i.read_cfg(8'h46, rd);
        chk_val(rd, `OCR_RDATA_NONE, "foreign code read");
        host_i.write_cfg(`OCR_CMD_CFG, 8'h5A);
        host_i.read_cfg(`OCR_CMD_CFG, rd);
        chk_val(rd, 8'h5A, "config write");
        foreach (retry_set[j]) run_retry(retry_set[j]);
        // brickwall: clamps, stays on even under the floor
        host_i.write_cfg(`OCR_CMD_CFG, {OCR_RESP_IGNORE, 3'h0, 3'h0});
        step(1);
        output_on_cmd <= 1'b1;
        wait_oe(1'b1);
        step(1);
        {oc_detect, vout_below_floor} <= 2'b11;
        step(4);
        #1;
        chk_bit(current_limit, 1'b1, "no clamp in ignore mode");
        chk_bit(output_enable, 1'b1, "ignore mode shut down");
        quiet();
        // conditioned: clamp above floor, shut down below it
        host_i.write_cfg(`OCR_CMD_CFG, {OCR_RESP_COND, 3'h0, 3'h0});
        step(1);
        output_on_cmd <= 1'b1;
        wait_oe(1'b1);
        step(1);
        oc_detect <= 1'b1;
        step(4);
        #1;
        chk_bit(current_limit, 1'b1, "no clamp above floor");
        chk_bit(output_enable, 1'b1, "shut down above floor");
        step(1);
        vout_below_floor <= 1'b1;
        wait_oe(1'b0);
        quiet();
        // delayed: code 2 is four units of limiting, then shutdown
        host_i.write_cfg(`OCR_CMD_CFG, {OCR_RESP_DELAY, 3'h0, 3'h2});
        step(1);
        output_on_cmd <= 1'b1;
        wait_oe(1'b1);
        step(1);
        {oc_detect, vout_below_floor} <= 2'b11;
        tick(3);
        step(3);
        #1;
        chk_bit(current_limit, 1'b1, "no clamp during delay");
        chk_bit(output_enable, 1'b1, "shut down before four units");
        tick(1);
        step(3);
        #1;
        chk_bit(output_enable, 1'b0, "still on after delay");
        quiet();
        close_out();
    end
endmodule : tb
